// *** design/gate_seq_pkg.sv ***
// Shared constants for the dual-image gate sequencer.
// Assumes a single 200 MHz clock; all times are converted to cycles here.
package gate_seq_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned DLY1_MIN_NS    = 85_000;
   localparam int unsigned DLY1_MIN_CYC   = (DLY1_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DLY2_MIN_PS    = 441_000;
   localparam int unsigned DLY2_MIN_CYC   = (DLY2_MIN_PS / 1000 * CLK_MHZ + 999) / 1000;
   localparam int unsigned SYNC_STEP_NS   = 100;
   localparam int unsigned SYNC_STEP_CYC  = SYNC_STEP_NS * CLK_MHZ / 1000;
   localparam int unsigned SYNC_MAX_STEPS = 9997;
   localparam int unsigned SYNC_W_NS      = 100;
   localparam int unsigned SYNC_W_CYC     = SYNC_W_NS * CLK_MHZ / 1000;
   localparam int unsigned FREQ_MIN_HZ    = 2;
   localparam int unsigned FREQ_MAX_HZ    = 1_000_000;
   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_FREQ   = 6'h04;
   localparam logic [5:0] OFS_G1_DLY = 6'h08;
   localparam logic [5:0] OFS_G1_WID = 6'h0C;
   localparam logic [5:0] OFS_G2_DLY = 6'h10;
   localparam logic [5:0] OFS_G2_WID = 6'h14;
   localparam logic [5:0] OFS_DECAY  = 6'h18;
   localparam logic [5:0] OFS_AUX_DLY = 6'h1C;
   localparam logic [5:0] OFS_AUX_WID = 6'h20;
   localparam logic [5:0] OFS_SYNC2  = 6'h24;
   localparam logic [5:0] OFS_STATUS = 6'h28;
   ////////////////////////////////////////////////////////////////////////////
   // Control field positions
   localparam int CB_DUAL   = 0;
   localparam int CB_PSHIFT = 1;
   localparam int CB_EXT    = 2;
   localparam int CB_RISE   = 3;
   localparam int CB_SYNC   = 4;
   localparam int CB_INTENS = 5;
   localparam int CB_RUN    = 6;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [6:0]  CTRL_RST  = 7'h08;
   localparam logic [31:0] FREQ_RST  = 32'h0000_03E8;
   localparam logic [31:0] G1D_RST   = 32'h0000_4268;
   localparam logic [31:0] G2D_RST   = 32'h0000_0059;
   localparam logic [31:0] WID_RST   = 32'h0000_0014;
   localparam logic [31:0] DECAY_RST = 32'h0000_0190;
   localparam logic [31:0] ZERO_RST  = 32'h0000_0000;
   localparam logic [13:0] SYNC2_RST = 14'h0000;
endpackage : gate_seq_pkg

// *** design/pulse_timer.sv ***
// One-shot pulse generator: programmable delay then programmable width.
// Start is ignored while a pulse is pending or running.
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Control
   input  wire logic         start_i,
   input  wire logic [W-1:0] dly_i,
   input  wire logic [W-1:0] wid_i,
   // Pulse
   output var  logic         pulse_o
);
   typedef enum logic [1:0] {P_IDLE, P_DLY, P_ON} phase_t;
   typedef struct packed {
      phase_t       ph;
      logic [W-1:0] cnt;
      logic         out;
   } pt_st_t;

   pt_st_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////////////
   // Next state; a zero width still gives one cycle so no pulse is lost
   always_comb begin
      s_d = s_q;
      case (s_q.ph)
         P_IDLE: begin
            if (start_i) begin
               s_d.ph  = P_DLY;
               s_d.cnt = dly_i;
            end
         end
         P_DLY: begin
            if (s_q.cnt == '0) begin
               s_d.ph  = P_ON;
               s_d.cnt = (wid_i == '0) ? '0 : wid_i - W'(1);
            end else begin
               s_d.cnt = s_q.cnt - W'(1);
            end
         end
         P_ON: begin
            if (s_q.cnt == '0) s_d.ph = P_IDLE;
            else s_d.cnt = s_q.cnt - W'(1);
         end
         default: s_d.ph = P_IDLE;
      endcase
      s_d.out = (s_d.ph == P_ON);
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) s_q <= '{ph: P_IDLE, cnt: '0, out: 1'b0};
      else s_q <= s_d;
   end

   assign pulse_o = s_q.out;
endmodule : pulse_timer
`default_nettype wire

// *** design/dual_image_gate_sequencer.sv ***
// Dual-image gate sequencer: gate pair, phosphor wait, shift, aux and sync.
// Assumes one 200 MHz clock, Avalon-MM register access, async trigger pin.
//
// Behaviour
// - Readout mode selects dual-image or full-frame
// - Per-readout: one trigger fires both gates
// - Per-shift: each gate waits own trigger
// - Separate delay and width per gate
// - First gate delay at least 85 us
// - Second gate delay at least 0.441 us
// - Wait programmed decay before each shift
// - Shift first image before second exposure
// - Internal or external trigger, selectable edge
// - Internal triggers at programmed frequency
// - Internal frequency 2 Hz to 1 MHz
// - Aux output with programmable delay, width
// - One switch enables both sync outputs
// - First sync pulses at internal frequency
// - Second sync delayed 0..999700 ns, 100 ns
// - Gates reach intensifier only when enabled
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dual_image_gate_sequencer (
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RST_I,
   // Avalon-MM slave
   input  wire logic [5:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   output var  logic [31:0] AVS_READDATA_O,
   output var  logic        AVS_WAITREQUEST_O,
   // Trigger pin
   input  wire logic        TRIG_I,
   // Camera outputs
   output var  logic        GATE_O,
   output var  logic        SHIFT_O,
   output var  logic        AUX_O,
   output var  logic        SYNC1_O,
   output var  logic        SYNC2_O
);
   typedef enum logic [3:0] {
      S_IDLE, S_DLY1, S_GATE1, S_DEC1, S_SHIFT1,
      S_WAIT2, S_DLY2, S_GATE2, S_DEC2, S_SHIFT2
   } seq_st_t;

   typedef struct packed {
      seq_st_t     st;
      logic [31:0] cnt;
      logic        dual_l;
      logic        pshift_l;
      logic [2:0]  tsync;
      logic        tlvl;
      logic [31:0] acc;
      logic        tick;
      logic [6:0]  ctrl;
      logic [31:0] freq;
      logic [31:0] g1d;
      logic [31:0] g1w;
      logic [31:0] g2d;
      logic [31:0] g2w;
      logic [31:0] decay;
      logic [31:0] adly;
      logic [31:0] awid;
      logic [13:0] s2dly;
      logic        wreq;
      logic [31:0] rdata;
      logic        gate;
      logic        shift;
      logic        aux;
      logic        sync1;
      logic        sync2;
      logic [15:0] pairs;
      logic [31:0] age;
   } top_st_t;

   top_st_t q, d;

   logic        aux_p;
   logic        sync1_p;
   logic        sync2_p;
   logic        trig;
   logic        ext_edge;
   logic        aux_go;
   logic [31:0] d1_eff;
   logic [31:0] d2_eff;
   logic [31:0] s2_cyc;
   logic [32:0] acc_sum;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] at_least(input logic [31:0] v, input logic [31:0] m);
      at_least = (v < m) ? m : v;
   endfunction : at_least

   function automatic logic [31:0] len_m1(input logic [31:0] v);
      len_m1 = (v == 32'h0000_0000) ? 32'h0000_0000 : v - 32'h0000_0001;
   endfunction : len_m1

   ////////////////////////////////////////////////////////////////////////////
   // Effective delays clamped to their minimum
   assign d1_eff  = at_least(q.g1d, 32'(gate_seq_pkg::DLY1_MIN_CYC));
   assign d2_eff  = at_least(q.g2d, 32'(gate_seq_pkg::DLY2_MIN_CYC));
   assign s2_cyc  = 32'(q.s2dly) * 32'(gate_seq_pkg::SYNC_STEP_CYC);
   assign acc_sum = {1'b0, q.acc} + {1'b0, q.freq};

   // Edge only once second and third stage agree; polarity chooses the edge
   assign ext_edge = (q.tsync[2] == q.tsync[1]) && (q.tsync[2] != q.tlvl)
                     && (q.tsync[2] == q.ctrl[gate_seq_pkg::CB_RISE]);
   assign trig = q.ctrl[gate_seq_pkg::CB_RUN]
                 && (q.ctrl[gate_seq_pkg::CB_EXT] ? ext_edge : q.tick);
   assign aux_go = trig && (q.st == S_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for bus, trigger front end and sequencer
   always_comb begin
      d = q;
      // Three-stage pin synchroniser
      d.tsync = {q.tsync[1:0], TRIG_I};
      if (q.tsync[2] == q.tsync[1]) d.tlvl = q.tsync[2];

      // Phase accumulator gives exact 1 Hz resolution without a divider
      d.tick = 1'b0;
      if (acc_sum >= 33'(gate_seq_pkg::CLK_HZ)) begin
         d.acc  = 32'(acc_sum - 33'(gate_seq_pkg::CLK_HZ));
         d.tick = 1'b1;
      end else begin
         d.acc = 32'(acc_sum);
      end

      // Bus: one wait cycle, read data captured on first cycle
      d.wreq = 1'b1;
      if ((AVS_READ_I || AVS_WRITE_I) && q.wreq) begin
         d.wreq  = 1'b0;
         d.rdata = 32'h0000_0000;
         case (AVS_ADDRESS_I)
            gate_seq_pkg::OFS_CTRL:    d.rdata = 32'(q.ctrl);
            gate_seq_pkg::OFS_FREQ:    d.rdata = q.freq;
            gate_seq_pkg::OFS_G1_DLY:  d.rdata = q.g1d;
            gate_seq_pkg::OFS_G1_WID:  d.rdata = q.g1w;
            gate_seq_pkg::OFS_G2_DLY:  d.rdata = q.g2d;
            gate_seq_pkg::OFS_G2_WID:  d.rdata = q.g2w;
            gate_seq_pkg::OFS_DECAY:   d.rdata = q.decay;
            gate_seq_pkg::OFS_AUX_DLY: d.rdata = q.adly;
            gate_seq_pkg::OFS_AUX_WID: d.rdata = q.awid;
            gate_seq_pkg::OFS_SYNC2:   d.rdata = 32'(q.s2dly);
            gate_seq_pkg::OFS_STATUS:  d.rdata = {q.pairs, 11'h000,
                                                  q.st != S_IDLE, q.st};
            default:                   d.rdata = 32'h0000_0000;
         endcase
      end

      // Write lands on the edge where waitrequest is seen low
      if (AVS_WRITE_I && !q.wreq) begin
         case (AVS_ADDRESS_I)
            gate_seq_pkg::OFS_CTRL:    d.ctrl = AVS_WRITEDATA_I[6:0];
            gate_seq_pkg::OFS_FREQ: begin
               if (AVS_WRITEDATA_I < 32'(gate_seq_pkg::FREQ_MIN_HZ))
                  d.freq = 32'(gate_seq_pkg::FREQ_MIN_HZ);
               else if (AVS_WRITEDATA_I > 32'(gate_seq_pkg::FREQ_MAX_HZ))
                  d.freq = 32'(gate_seq_pkg::FREQ_MAX_HZ);
               else
                  d.freq = AVS_WRITEDATA_I;
            end
            gate_seq_pkg::OFS_G1_DLY:  d.g1d   = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_G1_WID:  d.g1w   = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_G2_DLY:  d.g2d   = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_G2_WID:  d.g2w   = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_DECAY:   d.decay = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_AUX_DLY: d.adly  = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_AUX_WID: d.awid  = AVS_WRITEDATA_I;
            gate_seq_pkg::OFS_SYNC2: begin
               if (AVS_WRITEDATA_I > 32'(gate_seq_pkg::SYNC_MAX_STEPS))
                  d.s2dly = 14'(gate_seq_pkg::SYNC_MAX_STEPS);
               else
                  d.s2dly = AVS_WRITEDATA_I[13:0];
            end
            default: ;
         endcase
      end

      // Gate sequencer; triggers outside IDLE and WAIT2 fall through unused
      case (q.st)
         S_IDLE: begin
            if (trig) begin
               d.dual_l   = q.ctrl[gate_seq_pkg::CB_DUAL];
               d.pshift_l = q.ctrl[gate_seq_pkg::CB_PSHIFT];
               d.st       = S_DLY1;
               d.cnt      = d1_eff - 32'h0000_0001;
            end
         end
         S_DLY1: begin
            if (q.cnt == 32'h0000_0000) begin
               d.st  = S_GATE1;
               d.cnt = len_m1(q.g1w);
            end else d.cnt = q.cnt - 32'h0000_0001;
         end
         S_GATE1: begin
            if (q.cnt == 32'h0000_0000) begin
               d.st  = S_DEC1;
               d.cnt = len_m1(q.decay);
            end else d.cnt = q.cnt - 32'h0000_0001;
         end
         S_DEC1: begin
            if (q.cnt == 32'h0000_0000) d.st = S_SHIFT1;
            else d.cnt = q.cnt - 32'h0000_0001;
         end
         S_SHIFT1: begin
            if (!q.dual_l) begin
               d.st = S_IDLE;
            end else if (q.pshift_l) begin
               d.st = S_WAIT2;
            end else begin
               d.st  = S_DLY2;
               d.cnt = d2_eff - 32'h0000_0001;
            end
         end
         S_WAIT2: begin
            if (trig) begin
               d.st  = S_DLY2;
               d.cnt = d2_eff - 32'h0000_0001;
            end
         end
         S_DLY2: begin
            if (q.cnt == 32'h0000_0000) begin
               d.st  = S_GATE2;
               d.cnt = len_m1(q.g2w);
            end else d.cnt = q.cnt - 32'h0000_0001;
         end
         S_GATE2: begin
            if (q.cnt == 32'h0000_0000) begin
               d.st  = S_DEC2;
               d.cnt = len_m1(q.decay);
            end else d.cnt = q.cnt - 32'h0000_0001;
         end
         S_DEC2: begin
            if (q.cnt == 32'h0000_0000) d.st = S_SHIFT2;
            else d.cnt = q.cnt - 32'h0000_0001;
         end
         S_SHIFT2: begin
            d.st    = S_IDLE;
            d.pairs = q.pairs + 16'h0001;
         end
         default: d.st = S_IDLE;
      endcase

      // Registered outputs
      d.gate  = ((d.st == S_GATE1) || (d.st == S_GATE2))
                && q.ctrl[gate_seq_pkg::CB_INTENS];
      d.shift = (d.st == S_SHIFT1) || (d.st == S_SHIFT2);
      d.aux   = aux_p;
      d.sync1 = sync1_p && q.ctrl[gate_seq_pkg::CB_SYNC];
      d.sync2 = sync2_p && q.ctrl[gate_seq_pkg::CB_SYNC];
      d.age   = (d.st != q.st) ? 32'h0000_0000 : q.age + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         q <= '{st: S_IDLE, cnt: 32'h0000_0000, dual_l: 1'b0, pshift_l: 1'b0,
                tsync: 3'h0, tlvl: 1'b0, acc: 32'h0000_0000, tick: 1'b0,
                ctrl: gate_seq_pkg::CTRL_RST, freq: gate_seq_pkg::FREQ_RST,
                g1d: gate_seq_pkg::G1D_RST, g1w: gate_seq_pkg::WID_RST,
                g2d: gate_seq_pkg::G2D_RST, g2w: gate_seq_pkg::WID_RST,
                decay: gate_seq_pkg::DECAY_RST, adly: gate_seq_pkg::ZERO_RST,
                awid: gate_seq_pkg::WID_RST, s2dly: gate_seq_pkg::SYNC2_RST,
                wreq: 1'b1, rdata: 32'h0000_0000, gate: 1'b0, shift: 1'b0,
                aux: 1'b0, sync1: 1'b0, sync2: 1'b0, pairs: 16'h0000,
                age: 32'h0000_0000};
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Aux and sync pulse timers; sync2 shares sync1's tick so spacing is exact
   pulse_timer #(.W(32)) u_aux (
      .clk_i   (MCLK_I),
      .rst_i   (RST_I),
      .start_i (aux_go),
      .dly_i   (q.adly),
      .wid_i   (q.awid),
      .pulse_o (aux_p)
   );

   pulse_timer #(.W(32)) u_sync1 (
      .clk_i   (MCLK_I),
      .rst_i   (RST_I),
      .start_i (q.tick),
      .dly_i   (32'h0000_0000),
      .wid_i   (32'(gate_seq_pkg::SYNC_W_CYC)),
      .pulse_o (sync1_p)
   );

   pulse_timer #(.W(32)) u_sync2 (
      .clk_i   (MCLK_I),
      .rst_i   (RST_I),
      .start_i (q.tick),
      .dly_i   (s2_cyc),
      .wid_i   (32'(gate_seq_pkg::SYNC_W_CYC)),
      .pulse_o (sync2_p)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Port drive
   assign AVS_READDATA_O    = q.rdata;
   assign AVS_WAITREQUEST_O = q.wreq;
   assign GATE_O            = q.gate;
   assign SHIFT_O           = q.shift;
   assign AUX_O             = q.aux;
   assign SYNC1_O           = q.sync1;
   assign SYNC2_O           = q.sync2;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   property p_dly1_min;
      (q.st == S_GATE1) && ($past(q.st) == S_DLY1) |-> $past(q.age) >= 32'(16999);
   endproperty
   a_dly1_min: assert property (p_dly1_min) else $error("first gate opened early");

   property p_dly2_min;
      (q.st == S_GATE2) && ($past(q.st) == S_DLY2) |-> $past(q.age) >= 32'(88);
   endproperty
   a_dly2_min: assert property (p_dly2_min) else $error("second gate opened early");

   property p_decay;
      (q.st == S_SHIFT1) && $stable(q.decay) |-> $past(q.age) == len_m1(q.decay);
   endproperty
   a_decay: assert property (p_decay) else $error("decay wait wrong length");

   property p_gate_en;
      GATE_O |-> $past(q.ctrl[gate_seq_pkg::CB_INTENS]);
   endproperty
   a_gate_en: assert property (p_gate_en) else $error("gate without intensifier enable");

   property p_sync_off;
      !q.ctrl[gate_seq_pkg::CB_SYNC] ##1 !q.ctrl[gate_seq_pkg::CB_SYNC] |-> !SYNC1_O && !SYNC2_O;
   endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync output while off");

   property p_per_readout;
      (q.st == S_SHIFT1) && q.dual_l && !q.pshift_l |=> q.st == S_DLY2;
   endproperty
   a_per_readout: assert property (p_per_readout) else $error("second gate not launched");

   property p_per_shift;
      (q.st == S_DLY2) && ($past(q.st) == S_WAIT2) |-> $past(trig);
   endproperty
   a_per_shift: assert property (p_per_shift) else $error("second gate without trigger");

   property p_no_restart;
      (q.st == S_DLY1) && ($past(q.st) != S_DLY1) |-> $past(q.st) == S_IDLE;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("sequence restarted while busy");

   property p_full_frame;
      (q.st == S_SHIFT1) && !q.dual_l |=> q.st == S_IDLE;
   endproperty
   a_full_frame: assert property (p_full_frame) else $error("pair ran in full frame");

   property p_shift_first;
      (q.st == S_WAIT2) && ($past(q.st) != S_WAIT2) |-> $past(SHIFT_O);
   endproperty
   a_shift_first: assert property (p_shift_first) else $error("no shift before wait");

   property p_cov_pair;
      q.st == S_SHIFT2;
   endproperty
   c_pair: cover property (p_cov_pair);

   property p_cov_wait;
      (q.st == S_WAIT2) ##1 (q.st == S_DLY2);
   endproperty
   c_wait: cover property (p_cov_wait);

   property p_cov_sync2;
      SYNC2_O && !SYNC1_O;
   endproperty
   c_sync2: cover property (p_cov_sync2);
endmodule : dual_image_gate_sequencer
`default_nettype wire

// *** tb/trig_src.sv ***
// External trigger source model: one clean pulse per fire request.
// Assumes the bench raises fire for one cycle; pin idles low.
`timescale 1ns/1ps
`default_nettype none
module trig_src #(
   parameter int WID = 8
) (
   // Clock and request
   input  wire logic clk_i,
   input  wire logic fire_i,
   // Trigger pin
   output wire logic pin_o
);
   int cnt = 0;
   // Rising-edge pulse of fixed width, matching the edge select
   always @(posedge clk_i) begin
      if (fire_i && cnt == 0) cnt <= WID;
      else if (cnt != 0) cnt <= cnt - 1;
   end
   assign pin_o = (cnt != 0);
endmodule : trig_src
`default_nettype wire

// *** tb/dual_image_gate_sequencer_tb_top.sv ***
// Bench for the gate sequencer: Avalon tasks, pulse monitor, scenarios.
// Assumes the first gate delay floor of 17000 cycles; run stays near 75k cycles.
`timescale 1ns/1ps
`default_nettype none
module dual_image_gate_sequencer_tb_top;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, fire = 0;
   logic [5:0]  adr = '0;
   logic [31:0] wd = '0, rdat, q;
   logic        wreq, gate, shift, aux, s1, s2, pg = 0, ps = 0, p1 = 0, p2 = 0, pt = 0;
   wire logic   trig;
   int          bad_count = 0, comparisons = 0, cyc = 0, pin_t = 0, t0 = 0, gh = 0, ah = 0;
   int          g_r[$], g_f[$], s_r[$], y1[$], y2[$];
   logic [5:0]  ra [7] = '{gate_seq_pkg::OFS_CTRL, gate_seq_pkg::OFS_FREQ, gate_seq_pkg::OFS_G1_DLY,
      gate_seq_pkg::OFS_G2_DLY, gate_seq_pkg::OFS_G1_WID, gate_seq_pkg::OFS_DECAY, 6'h2C};
   logic [31:0] rv [7] = '{32'(gate_seq_pkg::CTRL_RST), gate_seq_pkg::FREQ_RST, gate_seq_pkg::G1D_RST,
      gate_seq_pkg::G2D_RST, gate_seq_pkg::WID_RST, gate_seq_pkg::DECAY_RST, gate_seq_pkg::ZERO_RST};
   logic [5:0]  ca [9] = '{gate_seq_pkg::OFS_G1_DLY, gate_seq_pkg::OFS_G1_WID, gate_seq_pkg::OFS_G2_DLY,
      gate_seq_pkg::OFS_G2_WID, gate_seq_pkg::OFS_DECAY, gate_seq_pkg::OFS_AUX_DLY,
      gate_seq_pkg::OFS_AUX_WID, gate_seq_pkg::OFS_SYNC2, gate_seq_pkg::OFS_FREQ};
   // Zero delays probe the floors; 1 MHz gives a 200-cycle tick
   logic [31:0] cd [9] = '{32'h0000_0000, 32'h0000_0005, 32'h0000_0000, 32'h0000_0003, 32'h0000_000A,
      32'h0000_000A, 32'h0000_0007, 32'h0000_0003, 32'h000F_4240};

   initial forever #2.5 clk = ~clk;

   dual_image_gate_sequencer dual_image_gate_sequencer_inst (.MCLK_I(clk), .RST_I(rst),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .TRIG_I(trig), .GATE_O(gate),
      .SHIFT_O(shift), .AUX_O(aux), .SYNC1_O(s1), .SYNC2_O(s2));
   trig_src trig_src_inst (.clk_i(clk), .fire_i(fire), .pin_o(trig));

   ////////////////////////////////////////
   // Edge log of gate, shift and sync outputs and trigger pin, high counts of gate and aux; timeout keeps a hang from running on
   always @(posedge clk) begin
      cyc++;
      if (trig && !pt) pin_t = cyc;
      if (gate && !pg) g_r.push_back(cyc);
      if (!gate && pg) g_f.push_back(cyc);
      if (shift && !ps) s_r.push_back(cyc);
      if (s1 && !p1) y1.push_back(cyc);
      if (s2 && !p2) y2.push_back(cyc);
      gh += int'(gate);
      ah += int'(aux);
      {pg, ps, p1, p2, pt} = {gate, shift, s1, s2, trig};
      if (cyc == 100000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] inr(input int v, input int lo, input int hi);
      return 32'(v >= lo && v <= hi);
   endfunction : inr

   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic shot(input int n);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : shot

   task automatic clr();
      g_r.delete(); g_f.delete(); s_r.delete(); y1.delete(); y2.delete();
      gh = 0;
      ah = 0;
   endtask : clr

   ////////////////////////////////////////
   // Scenarios
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         bus(0, ra[i], 0);
         chk("reset_or_unmapped", q, rv[i]);
      end
      for (int i = 0; i < 9; i++) bus(1, ca[i], cd[i]);
      // Per-readout pair; the extra trigger lands mid-sequence
      bus(1, gate_seq_pkg::OFS_CTRL, 32'h0000_006D);
      clr();
      shot(300);
      t0 = pin_t;
      shot(18000);
      chk("gate1_delay", inr(g_r[0] - t0, 17001, 17010), 1);
      chk("gate_count", g_r.size(), 2);
      chk("gate_cycles", gh, 8);
      chk("decay_wait", inr(s_r[0] - g_f[0], 10, 11), 1);
      chk("gate2_delay", inr(g_r[1] - s_r[0], 89, 91), 1);
      chk("aux_cycles", ah, 7);
      bus(0, gate_seq_pkg::OFS_STATUS, 0);
      chk("pair_count", q[31:16], 1);
      // Per-shift pair needs a second trigger
      bus(1, gate_seq_pkg::OFS_CTRL, 32'h0000_006F);
      clr();
      shot(18000);
      chk("shift_wait", s_r.size(), 1);
      shot(300);
      chk("gate2_from_trig", inr(g_r[1] - pin_t, 89, 98), 1);
      chk("shift_pair", s_r.size(), 2);
      // Full-frame readout gives a single gate
      bus(1, gate_seq_pkg::OFS_CTRL, 32'h0000_006C);
      clr();
      shot(18000);
      chk("ff_gates", g_r.size(), 1);
      // Internal ticks, intensifier off, sync on
      bus(1, gate_seq_pkg::OFS_CTRL, 32'h0000_0059);
      clr();
      repeat (18000) @(posedge clk);
      chk("gates_off", g_r.size(), 0);
      chk("internal_shifts", s_r.size(), 2);
      // The enable may land mid-pulse, so the first edges can be cut short; use later ones
      chk("sync1_period", y1[2] - y1[1], 200);
      chk("sync2_lag", (y2[1] - y1[1] + 400) % 200, 60);
      bus(1, gate_seq_pkg::OFS_FREQ, 0);
      bus(0, gate_seq_pkg::OFS_FREQ, 0);
      chk("freq_floor", q, 2);
      bus(1, gate_seq_pkg::OFS_CTRL, 32'h0000_0049);
      clr();
      repeat (1000) @(posedge clk);
      chk("sync_off", y1.size() + y2.size(), 0);
      close_out();
   end
endmodule : dual_image_gate_sequencer_tb_top
`default_nettype wire
